/* File: core/pwmcfe_pkg.sv */
// Shared constants for the PWM channel enable, polarity and clock select front end.
`default_nettype none
package pwmcfe_pkg;
  localparam int unsigned NUM_CHAN  = 8;
  localparam int unsigned NUM_PAIR  = 4;
  localparam int unsigned ADR_W     = 8;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned PCNT_W    = 7;
  localparam int unsigned SCNT_W    = 9;

  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_CHAN_ENABLE   = 6'h00;
  localparam logic [5:0] IDX_START_LEVEL   = 6'h01;
  localparam logic [5:0] IDX_CLOCK_SOURCE  = 6'h02;
  localparam logic [5:0] IDX_DIVIDER       = 6'h03;
  localparam logic [5:0] IDX_PAIR_JOIN     = 6'h05;
  localparam logic [5:0] IDX_SCALE_A       = 6'h08;
  localparam logic [5:0] IDX_SCALE_B       = 6'h09;
  localparam logic [5:0] IDX_PERIOD_BASE   = 6'h14;
  localparam logic [5:0] IDX_DUTY_BASE     = 6'h1C;
  localparam logic [5:0] IDX_RUN_STATUS    = 6'h30;

  // Field positions.
  localparam int unsigned DIV_A_LSB  = 0;
  localparam int unsigned DIV_B_LSB  = 4;
  localparam int unsigned JOIN_LSB   = 4;

  // Reset values.
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hFF;
  localparam logic [7:0] RST_DUTY    = 8'h80;
endpackage : pwmcfe_pkg
`default_nettype wire

/* File: core/pwmcfe_prescaler.sv */
// Prescaler producing clock A, clock B and the scaled clocks as one-cycle tick pulses.
`default_nettype none
module pwmcfe_prescaler (
  // Clock and reset
  input  wire  logic                                 clk_i,
  input  wire  logic                                 rst_i,
  // Control
  input  wire  logic                                 run_i,
  input  wire  logic [2:0]                           div_a_i,
  input  wire  logic [2:0]                           div_b_i,
  input  wire  logic [7:0]                           scale_a_i,
  input  wire  logic [7:0]                           scale_b_i,
  // Ticks and state
  output logic                                       tick_a_o,
  output logic                                       tick_b_o,
  output logic                                       tick_sa_o,
  output logic                                       tick_sb_o,
  output logic [pwmcfe_pkg::PCNT_W-1:0]              count_o
);
  logic [pwmcfe_pkg::PCNT_W-1:0] cnt_q;
  logic [pwmcfe_pkg::PCNT_W-1:0] mask_a;
  logic [pwmcfe_pkg::PCNT_W-1:0] mask_b;
  logic [pwmcfe_pkg::SCNT_W-1:0] sa_cnt_q;
  logic [pwmcfe_pkg::SCNT_W-1:0] sb_cnt_q;
  logic [pwmcfe_pkg::SCNT_W-1:0] sa_lim;
  logic [pwmcfe_pkg::SCNT_W-1:0] sb_lim;

  // A divide by two to the power n ticks when the low n counter bits are all ones.
  assign mask_a   = 7'((8'h01 << div_a_i) - 8'h01);
  assign mask_b   = 7'((8'h01 << div_b_i) - 8'h01);
  assign tick_a_o = run_i && ((cnt_q & mask_a) == mask_a);
  assign tick_b_o = run_i && ((cnt_q & mask_b) == mask_b);
  assign count_o  = cnt_q;

  // A scale of zero stands for 256, so the scaled period is 512 source ticks.
  assign sa_lim    = (scale_a_i == 8'h00) ? 9'h1FF : 9'({scale_a_i, 1'b0} - 9'h001);
  assign sb_lim    = (scale_b_i == 8'h00) ? 9'h1FF : 9'({scale_b_i, 1'b0} - 9'h001);
  assign tick_sa_o = tick_a_o && (sa_cnt_q >= sa_lim);
  assign tick_sb_o = tick_b_o && (sb_cnt_q >= sb_lim);

  // Counter is held at zero while idle so that it draws no toggle power.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      sa_cnt_q <= '0;
    end else if (tick_a_o) begin
      sa_cnt_q <= (sa_cnt_q >= sa_lim) ? 9'h000 : sa_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      sb_cnt_q <= '0;
    end else if (tick_b_o) begin
      sb_cnt_q <= (sb_cnt_q >= sb_lim) ? 9'h000 : sb_cnt_q + 9'h001;
    end
  end
endmodule // pwmcfe_prescaler
`default_nettype wire

/* File: core/pwmcfe_top.sv */
// Eight-channel PWM front end: enables, start level, clock select, pair joining, Wishbone slave.
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
module pwmcfe_top (
  // Clock and reset
  input  wire  logic                            clk_i,
  input  wire  logic                            rst_i,
  // Wishbone slave
  input  wire  logic                            wb_cyc_i,
  input  wire  logic                            wb_stb_i,
  input  wire  logic                            wb_we_i,
  input  wire  logic [pwmcfe_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire  logic [3:0]                      wb_sel_i,
  input  wire  logic [31:0]                     wb_dat_i,
  output logic [31:0]                           wb_dat_o,
  output logic                                  wb_ack_o,
  // Waveform outputs
  output logic [pwmcfe_pkg::NUM_CHAN-1:0]       pwm_o
);
  logic [7:0]                         chan_on_bit_q;
  logic [7:0]                         chan_start_level_bit_q;
  logic [7:0]                         chan_clock_choice_bit_q;
  logic [2:0]                         clock_a_divider_field_q;
  logic [2:0]                         clock_b_divider_field_q;
  logic [3:0]                         pair_join_bits_q;
  logic [7:0]                         scale_a_q;
  logic [7:0]                         scale_b_q;
  logic [7:0]                         period_q [pwmcfe_pkg::NUM_CHAN];
  logic [7:0]                         duty_q   [pwmcfe_pkg::NUM_CHAN];
  logic [7:0]                         run_q;
  logic [7:0]                         out_q;
  logic [7:0]                         cnt_q    [pwmcfe_pkg::NUM_CHAN];
  logic                               ack_q;
  logic [31:0]                        dat_q;
  logic [7:0]                         rd_byte;
  logic [pwmcfe_pkg::IDX_W-1:0]       idx;
  logic                               bus_req;
  logic                               wr_stb;
  logic [7:0]                         eff_en;
  logic [7:0]                         hi_joined;
  logic [7:0]                         src_tick;
  logic                               tick_a;
  logic                               tick_b;
  logic                               tick_sa;
  logic                               tick_sb;
  logic [pwmcfe_pkg::PCNT_W-1:0]      presc_cnt;

  assign idx     = wb_adr_i[pwmcfe_pkg::ADR_W-1:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_stb  = bus_req && wb_we_i && wb_sel_i[0];

  // Bus answer: one wait cycle, ack for exactly one cycle, unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      dat_q <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      pwmcfe_pkg::IDX_CHAN_ENABLE:  rd_byte = chan_on_bit_q;
      pwmcfe_pkg::IDX_START_LEVEL:  rd_byte = chan_start_level_bit_q;
      pwmcfe_pkg::IDX_CLOCK_SOURCE: rd_byte = chan_clock_choice_bit_q;
      pwmcfe_pkg::IDX_DIVIDER:      rd_byte = {1'b0, clock_b_divider_field_q, 1'b0, clock_a_divider_field_q};
      pwmcfe_pkg::IDX_PAIR_JOIN:    rd_byte = {pair_join_bits_q, 4'h0};
      pwmcfe_pkg::IDX_SCALE_A:      rd_byte = scale_a_q;
      pwmcfe_pkg::IDX_SCALE_B:      rd_byte = scale_b_q;
      pwmcfe_pkg::IDX_RUN_STATUS:   rd_byte = run_q;
      default: begin
        if (idx >= pwmcfe_pkg::IDX_PERIOD_BASE && idx < pwmcfe_pkg::IDX_DUTY_BASE) begin
          rd_byte = period_q[3'(idx - pwmcfe_pkg::IDX_PERIOD_BASE)];
        end else if (idx >= pwmcfe_pkg::IDX_DUTY_BASE && idx < 6'(pwmcfe_pkg::IDX_DUTY_BASE + 6'h08)) begin
          rd_byte = duty_q[3'(idx - pwmcfe_pkg::IDX_DUTY_BASE)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_on_bit_q <= pwmcfe_pkg::RST_BYTE;
    end else if (wr_stb && idx == pwmcfe_pkg::IDX_CHAN_ENABLE) begin
      chan_on_bit_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_start_level_bit_q <= pwmcfe_pkg::RST_BYTE;
    end else if (wr_stb && idx == pwmcfe_pkg::IDX_START_LEVEL) begin
      chan_start_level_bit_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_clock_choice_bit_q <= pwmcfe_pkg::RST_BYTE;
    end else if (wr_stb && idx == pwmcfe_pkg::IDX_CLOCK_SOURCE) begin
      chan_clock_choice_bit_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_a_divider_field_q <= 3'h0;
      clock_b_divider_field_q <= 3'h0;
      pair_join_bits_q        <= 4'h0;
      scale_a_q               <= pwmcfe_pkg::RST_BYTE;
      scale_b_q               <= pwmcfe_pkg::RST_BYTE;
    end else if (wr_stb) begin
      case (idx)
        pwmcfe_pkg::IDX_DIVIDER: begin
          clock_a_divider_field_q <= wb_dat_i[pwmcfe_pkg::DIV_A_LSB +: 3];
          clock_b_divider_field_q <= wb_dat_i[pwmcfe_pkg::DIV_B_LSB +: 3];
        end
        pwmcfe_pkg::IDX_PAIR_JOIN: pair_join_bits_q <= wb_dat_i[pwmcfe_pkg::JOIN_LSB +: 4];
        pwmcfe_pkg::IDX_SCALE_A:   scale_a_q        <= wb_dat_i[7:0];
        pwmcfe_pkg::IDX_SCALE_B:   scale_b_q        <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  pwmcfe_prescaler u_presc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (|chan_on_bit_q),
    .div_a_i   (clock_a_divider_field_q),
    .div_b_i   (clock_b_divider_field_q),
    .scale_a_i (scale_a_q),
    .scale_b_i (scale_b_q),
    .tick_a_o  (tick_a),
    .tick_b_o  (tick_b),
    .tick_sa_o (tick_sa),
    .tick_sb_o (tick_sb),
    .count_o   (presc_cnt)
  );

  genvar gi;
  generate
    for (gi = 0; gi < pwmcfe_pkg::NUM_CHAN; gi++) begin : g_chan
      localparam bit IS_HI  = (gi % 2) == 0;
      localparam bit GRP_B  = ((gi / 2) % 2) == 1;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          period_q[gi] <= pwmcfe_pkg::RST_PERIOD;
          duty_q[gi]   <= pwmcfe_pkg::RST_DUTY;
        end else if (wr_stb && idx == 6'(pwmcfe_pkg::IDX_PERIOD_BASE + 6'(gi))) begin
          period_q[gi] <= wb_dat_i[7:0];
        end else if (wr_stb && idx == 6'(pwmcfe_pkg::IDX_DUTY_BASE + 6'(gi))) begin
          duty_q[gi]   <= wb_dat_i[7:0];
        end
      end

      assign hi_joined[gi] = IS_HI ? pair_join_bits_q[gi/2] : 1'b0;
      assign eff_en[gi]    = chan_on_bit_q[gi] && !hi_joined[gi];

      if (GRP_B) begin : g_b
        assign src_tick[gi] = chan_clock_choice_bit_q[gi] ? tick_sb : tick_b;
      end else begin : g_a
        assign src_tick[gi] = chan_clock_choice_bit_q[gi] ? tick_sa : tick_a;
      end

      always_ff @(posedge clk_i) begin
        if (rst_i || !eff_en[gi]) begin
          run_q[gi] <= 1'b0;
        end else if (src_tick[gi]) begin
          run_q[gi] <= 1'b1;
        end
      end
    end

    for (gi = 0; gi < pwmcfe_pkg::NUM_PAIR; gi++) begin : g_pair
      localparam int HI = 2 * gi;
      localparam int LO = 2 * gi + 1;
      logic        joined;
      logic [15:0] cnt16;
      logic [15:0] per16;
      logic [15:0] duty16;
      logic        lvl_lo;
      logic        lvl_hi;

      assign joined = pair_join_bits_q[gi];
      assign cnt16  = {cnt_q[HI], cnt_q[LO]};
      assign per16  = {period_q[HI], period_q[LO]};
      assign duty16 = {duty_q[HI], duty_q[LO]};

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q[HI] <= 8'h00;
          cnt_q[LO] <= 8'h00;
        end else if (joined) begin
          if (!run_q[LO]) begin
            {cnt_q[HI], cnt_q[LO]} <= 16'h0000;
          end else if (src_tick[LO]) begin
            {cnt_q[HI], cnt_q[LO]} <= (cnt16 + 16'h0001 >= per16) ? 16'h0000 : cnt16 + 16'h0001;
          end
        end else begin
          if (!run_q[HI]) begin
            cnt_q[HI] <= 8'h00;
          end else if (src_tick[HI]) begin
            cnt_q[HI] <= (9'(cnt_q[HI]) + 9'h001 >= 9'(period_q[HI])) ? 8'h00 : cnt_q[HI] + 8'h01;
          end
          if (!run_q[LO]) begin
            cnt_q[LO] <= 8'h00;
          end else if (src_tick[LO]) begin
            cnt_q[LO] <= (9'(cnt_q[LO]) + 9'h001 >= 9'(period_q[LO])) ? 8'h00 : cnt_q[LO] + 8'h01;
          end
        end
      end

      assign lvl_lo = joined ? ((cnt16 < duty16) ? chan_start_level_bit_q[LO] : !chan_start_level_bit_q[LO])
                             : ((cnt_q[LO] < duty_q[LO]) ? chan_start_level_bit_q[LO]
                                                          : !chan_start_level_bit_q[LO]);
      assign lvl_hi = (cnt_q[HI] < duty_q[HI]) ? chan_start_level_bit_q[HI] : !chan_start_level_bit_q[HI];

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_q[HI] <= 1'b0;
          out_q[LO] <= 1'b0;
        end else begin
          out_q[LO] <= run_q[LO] && lvl_lo;
          out_q[HI] <= run_q[HI] && !joined && lvl_hi;
        end
      end

      AST_LEVEL_AT_START: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_q[LO] && !joined && cnt_q[LO] == 8'h00 && duty_q[LO] != 8'h00)
          |=> (out_q[LO] == $past(chan_start_level_bit_q[LO])))
        else $error("output did not show start level at period start");

      AST_LEVEL_AFTER_DUTY: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_q[HI] && !joined && cnt_q[HI] >= duty_q[HI])
          |=> (out_q[HI] == !$past(chan_start_level_bit_q[HI])))
        else $error("output did not flip after duty count");

      AST_HI_HELD_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        joined [*2] |-> (!out_q[HI] && !run_q[HI]))
        else $error("joined high-order channel not held off");

      AST_PAIR_OFF_BY_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        (joined && !chan_on_bit_q[LO]) |=> ##1 (!out_q[LO]))
        else $error("joined pair kept running after low-order disable");
    end
  endgenerate

  assign pwm_o = out_q;

  AST_RUN_NEEDS_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    ((run_q & ~$past(run_q)) & ~$past(src_tick & eff_en)) == 8'h00)
    else $error("channel started without a source tick");

  AST_PRESC_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    (chan_on_bit_q == 8'h00) [*2] |-> (presc_cnt == 7'h00 && !tick_a && !tick_b))
    else $error("prescaler runs while all channels are off");

  AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && idx == pwmcfe_pkg::IDX_CHAN_ENABLE) |=> (chan_on_bit_q == $past(wb_dat_i[7:0])))
    else $error("enable register write not stored");

  AST_LEVEL_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !wb_we_i && idx == pwmcfe_pkg::IDX_START_LEVEL)
      |=> (wb_ack_o && wb_dat_o[7:0] == $past(chan_start_level_bit_q)))
    else $error("start level read returned wrong value");

  AST_CLK_SEL_A: assert property (@(posedge clk_i) disable iff (rst_i)
    !chan_clock_choice_bit_q[0] |-> (src_tick[0] == tick_a))
    else $error("channel 0 not clocked from clock A");

  AST_CLK_SEL_SB: assert property (@(posedge clk_i) disable iff (rst_i)
    chan_clock_choice_bit_q[7] |-> (src_tick[7] == tick_sb))
    else $error("channel 7 not clocked from scaled clock B");

  AST_DIV_BY_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (clock_a_divider_field_q == 3'h0 && chan_on_bit_q != 8'h00) |-> tick_a)
    else $error("clock A missed a tick at divide by one");

  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    $past(rst_i) |-> (chan_on_bit_q == 8'h00 && chan_start_level_bit_q == 8'h00
                      && chan_clock_choice_bit_q == 8'h00 && pwm_o == 8'h00))
    else $error("control registers not cleared by reset");
endmodule // pwmcfe_top
`default_nettype wire

/* File: verif/pwmcfe_top_tb.sv */
// Self-checking testbench for the PWM channel enable, start level and clock select front end.
`default_nettype none
module pwmcfe_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  pwm_o;
  int          error_cnt;
  int          checks;
  logic [7:0]  rnd;
  logic [31:0] rd;
  logic [5:0]  idx;
  logic [7:0]  en;
  logic [7:0]  pl;
  logic [7:0]  cs;
  logic [3:0]  jn;
  logic [7:0]  live;
  int          hi;
  int          g_rise[8];
  int          g_high[8];
  int          e_rise[8];
  int          e_high[8];

  pwmcfe_top pwmcfe_top_inst (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .pwm_o    (pwm_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [5:0] ix, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {ix, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk({31'h00000000, wb_ack_o}, 32'h00000001);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Windows of 64 cycles hold whole periods, so counts do not depend on phase.
  task automatic measure();
    logic [7:0] prev;
    prev = pwm_o;
    for (int c = 0; c < 8; c++) begin
      g_rise[c] = 0;
      g_high[c] = 0;
    end
    repeat (64) begin
      @(posedge clk_i);
      for (int c = 0; c < 8; c++) begin
        g_high[c] += (pwm_o[c] === 1'b1) ? 1 : 0;
        g_rise[c] += (pwm_o[c] === 1'b1 && prev[c] === 1'b0) ? 1 : 0;
      end
      prev = pwm_o;
    end
  endtask

  // Clock A runs at the bus rate, clock B at half; both scales are one, doubling the tick spacing.
  task automatic model();
    int cyc;
    for (int c = 0; c < 8; c++) begin
      cyc = (c % 4 < 2) ? 1 : 2;
      if (cs[c]) cyc = cyc * 2;
      e_rise[c] = en[c] ? 64 / (4 * cyc) : 0;
      e_high[c] = en[c] ? (pl[c] ? 1 : 3) * cyc * e_rise[c] : 0;
      if (jn[c / 2] && c % 2 == 0) begin
        e_rise[c] = 0;
        e_high[c] = 0;
      end
    end
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    error_cnt = 0;
    checks = 0;
    rnd = 8'h27;
    jn = 4'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({24'h000000, pwm_o}, 32'h00000000);
    for (int r = 0; r < 3; r++) begin
      wb_xfer(1'b0, pwmcfe_pkg::IDX_CHAN_ENABLE + 6'(r), 8'h00);
      chk(rd, 32'h00000000);
    end
    for (int r = 0; r < 4; r++) begin
      idx = (r == 3) ? 6'h3F : pwmcfe_pkg::IDX_CHAN_ENABLE + 6'(r);
      rnd = lfsr(rnd);
      wb_xfer(1'b1, idx, rnd);
      wb_xfer(1'b0, idx, 8'h00);
      chk(rd, (r == 3) ? 32'h00000000 : {24'h000000, rnd});
    end
    for (int c = 0; c < 8; c++) begin
      wb_xfer(1'b1, pwmcfe_pkg::IDX_PERIOD_BASE + 6'(c), 8'h04);
      wb_xfer(1'b1, pwmcfe_pkg::IDX_DUTY_BASE + 6'(c), 8'h01);
    end
    wb_xfer(1'b1, pwmcfe_pkg::IDX_CHAN_ENABLE, 8'h00);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_START_LEVEL, 8'h01);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_CLOCK_SOURCE, 8'h00);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_DIVIDER, 8'h17);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_CHAN_ENABLE, 8'h01);
    // The idle prescaler restarts from zero, so the first clock A tick is 128 cycles away.
    hi = 0;
    repeat (100) begin
      @(posedge clk_i);
      hi += (pwm_o !== 8'h00) ? 1 : 0;
    end
    chk(32'(hi), 32'h00000000);
    repeat (40) @(posedge clk_i);
    chk({24'h000000, pwm_o}, 32'h00000001);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_DIVIDER, 8'h10);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_SCALE_A, 8'h01);
    wb_xfer(1'b1, pwmcfe_pkg::IDX_SCALE_B, 8'h01);
    for (int it = 0; it < 9; it++) begin
      if (it == 6) begin
        jn = 4'hF;
        wb_xfer(1'b1, pwmcfe_pkg::IDX_PAIR_JOIN, 8'hF0);
        for (int c = 0; c < 8; c += 2) begin
          wb_xfer(1'b1, pwmcfe_pkg::IDX_PERIOD_BASE + 6'(c), 8'h00);
          wb_xfer(1'b1, pwmcfe_pkg::IDX_DUTY_BASE + 6'(c), 8'h00);
        end
      end
      rnd = lfsr(rnd);
      en = (it == 5) ? 8'h00 : rnd;
      rnd = lfsr(rnd);
      pl = rnd;
      rnd = lfsr(rnd);
      cs = rnd;
      wb_xfer(1'b1, pwmcfe_pkg::IDX_CHAN_ENABLE, en);
      wb_xfer(1'b1, pwmcfe_pkg::IDX_START_LEVEL, pl);
      wb_xfer(1'b1, pwmcfe_pkg::IDX_CLOCK_SOURCE, cs);
      model();
      // A joined pair's high-order channel never runs, whatever its enable bit says.
      live = en & ~{1'b0, jn[3], 1'b0, jn[2], 1'b0, jn[1], 1'b0, jn[0]};
      repeat (40) @(posedge clk_i);
      measure();
      chk({24'h000000, pwm_o & ~live}, 32'h00000000);
      for (int c = 0; c < 8; c++) begin
        chk(32'(g_rise[c]), 32'(e_rise[c]));
        chk(32'(g_high[c]), 32'(e_high[c]));
      end
      wb_xfer(1'b0, pwmcfe_pkg::IDX_RUN_STATUS, 8'h00);
      chk(rd, {24'h000000, live});
    end
    // A reset in mid-run must clear the live control registers and silence the outputs.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({24'h000000, pwm_o}, 32'h00000000);
    for (int r = 0; r < 3; r++) begin
      wb_xfer(1'b0, pwmcfe_pkg::IDX_CHAN_ENABLE + 6'(r), 8'h00);
      chk(rd, 32'h00000000);
    end
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // pwmcfe_top_tb
`default_nettype wire
